// [sbd_pkg.sv]
// Shared constants for the stepper bridge drive control block.
// Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register port.
package sbd_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;       // 20 MHz core clock
   localparam int unsigned TIME_SLOT_NS = 25000;     // One bus time slot
   localparam int unsigned SLOT_CYCLES = TIME_SLOT_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_W = 12;               // Width of slot cycle counter
   localparam int unsigned SLOT_W = 4;               // Width of held-slot counter
   localparam logic [SLOT_W-1:0] HOLD_SLOTS_SHORT = 4'h9;  // Shorted bus
   localparam logic [SLOT_W-1:0] HOLD_SLOTS_OVERV = 4'h8;  // Overvoltage, 200 us
   localparam logic [SLOT_W-1:0] HOLD_SLOTS_MAX = 4'hF;

   // -----------------------------------------------------------------
   // Command bit positions, in order of arrival
   // -----------------------------------------------------------------
   localparam int unsigned CMD_W = 5;
   localparam int unsigned CMD_INH_A = 0;
   localparam int unsigned CMD_DIR_A = 1;
   localparam int unsigned CMD_ENERGIZE = 2;
   localparam int unsigned CMD_DIR_B = 3;
   localparam int unsigned CMD_INH_B = 4;
   localparam logic [CMD_W-1:0] CMD_RESET = 5'h00;

   // -----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_HOLD = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam int unsigned CTRL_FORCE_OFF = 0;
   localparam int unsigned STAT_CMD_LSB = 0;
   localparam int unsigned STAT_DISABLED = 8;
   localparam int unsigned STAT_BUS_LEVEL = 9;
   localparam int unsigned STAT_SLOTS_LSB = 12;
   localparam logic CTRL_FORCE_OFF_RESET = 1'b0;
   localparam logic [SLOT_W-1:0] HOLD_RESET = HOLD_SLOTS_SHORT;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sbd_pkg

// [sbd_lowhold_timer.sv]
// Held-low timer: synchronises the bus pin and counts whole time slots
// of continuous dominant level.
// Assumes the bus pin is asynchronous to core_clk.
`timescale 1ns/10ps
module sbd_lowhold_timer
   import sbd_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic bus_pin,
   output logic bus_level,
   output logic [SLOT_W-1:0] held_slots
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic [CYC_W-1:0] cyc;
      logic [SLOT_W-1:0] slots;
   } sbd_timer_type;

   sbd_timer_type st_ff;
   sbd_timer_type nxt_st;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // Stage one feeds only stage two; counting looks at stage two
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = bus_pin;
      nxt_st.s2 = st_ff.s1;
      // [RL13] recessive restarts count
      if (st_ff.s2) begin
         nxt_st.cyc = '0;
         nxt_st.slots = '0;
      end else if (st_ff.cyc == CYC_W'(SLOT_CYC - 1)) begin
         // [RL13] whole slots only
         nxt_st.cyc = '0;
         if (st_ff.slots != HOLD_SLOTS_MAX) begin
            nxt_st.slots = st_ff.slots + 4'h1;
         end
      end else begin
         nxt_st.cyc = st_ff.cyc + 12'h001;
      end
   end

   // Reset as recessive, so no false count at start-up
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{s1: 1'b1, s2: 1'b1, cyc: '0, slots: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus_level = st_ff.s2;
   assign held_slots = st_ff.slots;

endmodule : sbd_lowhold_timer

// [sbd_bridge_ctrl.sv]
// Stepper bridge drive control: latches command bits from the frame
// decoder into two H-bridge drive states and shuts all bridges off when
// the bus is held dominant too long.
// Assumes a frame decoder on core_clk supplies command bits, a push-valid
// level and the pull-sync level; the bus pin itself is asynchronous.
//
// Functional notes
// [RL1] Bus held dominant nine time slots disables every bridge output.
// [RL2] Master may hold bus low nine slots or more to stop all slaves.
// [RL3] After held-low disable, next standard instruction restores outputs.
// [RL4] Overvoltage low lasting eight slots, 200 us, also disables outputs; here only once REG_HOLD is written to 8 (reset limit nine).
// [RL5] After overvoltage, master sends standard instruction; slave then restores outputs.
// [RL6] First direction bit steers bridge A current, second steers bridge B.
// [RL7] Full step: master keeps both coils on, flips one direction per step.
// [RL8] Half step: master alternates single energized coil, other off.
// [RL9] Each bridge terminal is driven high, driven low, or high impedance.
// [RL10] Recessive pulled-up bus is logic one; dominant low is logic zero.
// [RL11] Command bits: inhibit A, direction A, energize, direction B, inhibit B.
// [RL12] Command latched on pull-sync rising edge, only after push field valid.
// [RL13] Disable timer counts whole low slots, restarts on recessive, holds until instruction.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module sbd_bridge_ctrl
   import sbd_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   // Bus pin and frame decoder
   input wire logic bus_pin,
   input wire logic [CMD_W-1:0] cmd_bits,
   input wire logic push_valid,
   input wire logic pull_sync,
   // Bridge terminals
   output logic coil_a_out_p,
   output logic coil_a_out_p_oe_n,
   output logic coil_a_out_n,
   output logic coil_a_out_n_oe_n,
   output logic coil_b_out_p,
   output logic coil_b_out_p_oe_n,
   output logic coil_b_out_n,
   output logic coil_b_out_n_oe_n,
   output logic outputs_disabled,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic awready;
      logic aw_hold;
      logic [ADDR_W-1:0] aw_addr;
      logic wready;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic force_off;
      logic [SLOT_W-1:0] hold_limit;
      logic [CMD_W-1:0] cmd;
      logic sync_prev;
      logic disabled;
      logic [3:0] drv;      // a_p, a_n, b_p, b_n levels
      logic [3:0] drv_oe_n; // low while driving
   } sbd_ctrl_type;

   sbd_ctrl_type st_ff;
   sbd_ctrl_type nxt_st;

   logic bus_level;
   logic [SLOT_W-1:0] held_slots;

   // -----------------------------------------------------------------
   // Held-low timer
   // -----------------------------------------------------------------
   // [RL10] dominant low counts as zero
   sbd_lowhold_timer #(
      .SLOT_CYC(SLOT_CYC)
   ) u_timer (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .bus_pin(bus_pin),
      .bus_level(bus_level),
      .held_slots(held_slots)
   );

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic latch_evt;
      logic hold_trip;
      logic [CMD_W-1:0] c;
      logic [SLOT_W-1:0] wlim;
      latch_evt = 1'b0;
      hold_trip = 1'b0;
      c = '0;
      wlim = '0;
      nxt_st = st_ff;

      // Address and data channels are taken independently
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_hold = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Commit a write once both halves are held
      if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid) begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         case (st_ff.aw_addr)
            REG_CTRL: begin
               if (st_ff.w_strb[0]) begin
                  nxt_st.force_off = st_ff.w_data[CTRL_FORCE_OFF];
               end
            end
            REG_HOLD: begin
               // A limit of zero would trip at all times, even with the bus recessive, so floor at one
               wlim = st_ff.w_data[SLOT_W-1:0];
               if (st_ff.w_strb[0]) begin
                  nxt_st.hold_limit = (wlim == '0) ? 4'h1 : wlim;
               end
            end
            REG_STATUS: begin
               // Read-only; write ignored
            end
            default: begin
               nxt_st.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read channel: answer one cycle after the address is taken
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         nxt_st.rdata = '0;
         case (s_axi_araddr)
            REG_CTRL: begin
               nxt_st.rdata[CTRL_FORCE_OFF] = st_ff.force_off;
            end
            REG_HOLD: begin
               nxt_st.rdata[SLOT_W-1:0] = st_ff.hold_limit;
            end
            REG_STATUS: begin
               nxt_st.rdata[STAT_CMD_LSB +: CMD_W] = st_ff.cmd;
               nxt_st.rdata[STAT_DISABLED] = st_ff.disabled;
               nxt_st.rdata[STAT_BUS_LEVEL] = bus_level;
               nxt_st.rdata[STAT_SLOTS_LSB +: SLOT_W] = held_slots;
            end
            default: begin
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Ready flags track the holding registers, one item at a time
      nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_hold && !nxt_st.bvalid;
      nxt_st.arready = !nxt_st.rvalid;

      // [RL12] latch on pull-sync edge
      nxt_st.sync_prev = pull_sync;
      latch_evt = pull_sync && !st_ff.sync_prev && push_valid;
      if (latch_evt) begin
         nxt_st.cmd = cmd_bits;
      end

      // [RL1] [RL4] held-low trip point
      hold_trip = (held_slots >= st_ff.hold_limit);
      // [RL3] [RL5] [RL13] instruction clears, trip wins
      if (hold_trip) begin
         nxt_st.disabled = 1'b1;
      end else if (latch_evt) begin
         nxt_st.disabled = 1'b0;
      end

      // [RL11] [RL6] bit meaning and bridge steering
      c = nxt_st.cmd;
      nxt_st.drv = '0;
      nxt_st.drv_oe_n = 4'hF;
      // [RL9] drive high, low or release
      if (!nxt_st.disabled && !nxt_st.force_off && c[CMD_ENERGIZE]) begin
         if (c[CMD_INH_A]) begin
            nxt_st.drv[3] = !c[CMD_DIR_A];
            nxt_st.drv[2] = c[CMD_DIR_A];
            nxt_st.drv_oe_n[3:2] = 2'h0;
         end
         if (c[CMD_INH_B]) begin
            nxt_st.drv[1] = !c[CMD_DIR_B];
            nxt_st.drv[0] = c[CMD_DIR_B];
            nxt_st.drv_oe_n[1:0] = 2'h0;
         end
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // Bridges start released and the bus port idle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{awready: 1'b1, aw_hold: 1'b0, aw_addr: '0,
                    wready: 1'b1, w_hold: 1'b0, w_data: '0, w_strb: '0,
                    bvalid: 1'b0, bresp: RESP_OKAY,
                    arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY,
                    force_off: CTRL_FORCE_OFF_RESET, hold_limit: HOLD_RESET,
                    cmd: CMD_RESET, sync_prev: 1'b0, disabled: 1'b0,
                    drv: 4'h0, drv_oe_n: 4'hF};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign coil_a_out_p = st_ff.drv[3];
   assign coil_a_out_n = st_ff.drv[2];
   assign coil_b_out_p = st_ff.drv[1];
   assign coil_b_out_n = st_ff.drv[0];
   assign coil_a_out_p_oe_n = st_ff.drv_oe_n[3];
   assign coil_a_out_n_oe_n = st_ff.drv_oe_n[2];
   assign coil_b_out_p_oe_n = st_ff.drv_oe_n[1];
   assign coil_b_out_n_oe_n = st_ff.drv_oe_n[0];
   assign outputs_disabled = st_ff.disabled;

   // Bus port outputs
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;

endmodule : sbd_bridge_ctrl

// [sbd_asserts.sv]
// Port checker for the bridge drive control block.
// Bound onto sbd_bridge_ctrl; sees only its ports.
`timescale 1ns/10ps
module sbd_asserts
   import sbd_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic bus_pin,
   input wire logic [CMD_W-1:0] cmd_bits,
   input wire logic push_valid,
   input wire logic pull_sync,
   input wire logic coil_a_out_p,
   input wire logic coil_a_out_p_oe_n,
   input wire logic coil_a_out_n,
   input wire logic coil_a_out_n_oe_n,
   input wire logic coil_b_out_p,
   input wire logic coil_b_out_p_oe_n,
   input wire logic coil_b_out_n,
   input wire logic coil_b_out_n_oe_n,
   input wire logic outputs_disabled
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic ps_ff, up_ff, latch, all_z;
   logic [15:0] low_ff;
   assign latch = pull_sync & ~ps_ff & push_valid;
   assign all_z = coil_a_out_p_oe_n & coil_a_out_n_oe_n
      & coil_b_out_p_oe_n & coil_b_out_n_oe_n;
   // Raw low run; saturates so a long short never wraps
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ps_ff <= 1'b0;
         up_ff <= 1'b0;
         low_ff <= 16'h0000;
      end else begin
         ps_ff <= pull_sync;
         up_ff <= 1'b1;
         if (bus_pin) low_ff <= 16'h0000;
         else if (low_ff != 16'hFFFF) low_ff <= low_ff + 16'h0001;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_oe_pair;
      (coil_a_out_p_oe_n == coil_a_out_n_oe_n) && (coil_b_out_p_oe_n == coil_b_out_n_oe_n);
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("bridge enables split");
   property p_opp;
      (coil_a_out_p_oe_n || coil_a_out_p != coil_a_out_n)
         && (coil_b_out_p_oe_n || coil_b_out_p != coil_b_out_n);
   endproperty
   a_opp: assert property (p_opp) else $error("driven terminals equal");
   property p_dis_z; outputs_disabled |-> all_z; endproperty
   a_dis_z: assert property (p_dis_z) else $error("driving while disabled");
   property p_dir;
      latch |=> (coil_a_out_p_oe_n || coil_a_out_n == $past(cmd_bits[CMD_DIR_A]))
         && (coil_b_out_p_oe_n || coil_b_out_n == $past(cmd_bits[CMD_DIR_B]));
   endproperty
   a_dir: assert property (p_dir) else $error("wrong current direction");
   property p_inh;
      latch |=> ($past(cmd_bits[CMD_ENERGIZE] & cmd_bits[CMD_INH_A]) || coil_a_out_p_oe_n)
         && ($past(cmd_bits[CMD_ENERGIZE] & cmd_bits[CMD_INH_B]) || coil_b_out_p_oe_n);
   endproperty
   a_inh: assert property (p_inh) else $error("bridge driven while off");
   property p_trip_min; $rose(outputs_disabled) |-> low_ff >= 8 * SLOT_CYC; endproperty
   a_trip_min: assert property (p_trip_min) else $error("disable too early");
   property p_trip_max; low_ff == 9 * SLOT_CYC + 6 |-> outputs_disabled; endproperty
   a_trip_max: assert property (p_trip_max) else $error("disable too late");
   property p_resume; latch && bus_pin && $past(bus_pin, 4) |=> !outputs_disabled; endproperty
   a_resume: assert property (p_resume) else $error("no resume on instruction");
   property p_hold; up_ff && $fell(outputs_disabled) |-> $past(latch); endproperty
   a_hold: assert property (p_hold) else $error("disable dropped alone");
   c_trip: cover property ($rose(outputs_disabled));
   c_resume: cover property (up_ff && $fell(outputs_disabled));
   c_full_on: cover property (latch && cmd_bits == 5'h1F);
endmodule : sbd_asserts

// [sbd_master_model.sv]
// Bus master model: sends instructions and holds the line dominant.
// Runs on the bench clock; tasks are called by the bench.
`timescale 1ns/10ps
module sbd_master_model
   import sbd_pkg::*;
(
   input wire logic core_clk,
   output logic bus_pin,
   output logic [CMD_W-1:0] cmd_bits,
   output logic push_valid,
   output logic pull_sync
);
   // ----------------------------------------------------------------
   // Idle levels at time zero
   // ----------------------------------------------------------------
   initial begin
      bus_pin = 1'b1;
      cmd_bits = CMD_RESET;
      push_valid = 1'b0;
      pull_sync = 1'b0;
   end
   task automatic send(input logic [CMD_W-1:0] c, input logic pv);
      @(posedge core_clk);
      cmd_bits <= c;
      push_valid <= pv;
      @(posedge core_clk);
      pull_sync <= 1'b1;
      @(posedge core_clk);
      pull_sync <= 1'b0;
      push_valid <= 1'b0;
      cmd_bits <= ~c; // Stale bits must not be relied on
   endtask : send
   task automatic hold_low(input int n);
      @(posedge core_clk);
      bus_pin <= 1'b0;
      repeat (n) @(posedge core_clk);
      bus_pin <= 1'b1;
      repeat (4) @(posedge core_clk); // Let the sync chain see recessive
   endtask : hold_low
endmodule : sbd_master_model

// [tb.sv]
// Self-checking bench for the bridge drive control block.
// Frames come from the master model, registers over AXI4-Lite.
`timescale 1ns/10ps
module tb
   import sbd_pkg::*;
;
   localparam int unsigned SC = 4; // Short slots keep the run brief
   localparam int STEPS [12] = '{21, 29, 31, 23, 21, 5, 29, 28, 31, 7, 23, 20};
   logic core_clk, arst_n, bus_pin, push_valid, pull_sync, outputs_disabled;
   logic [CMD_W-1:0] cmd_bits;
   logic coil_a_out_p, coil_a_out_p_oe_n, coil_a_out_n, coil_a_out_n_oe_n;
   logic coil_b_out_p, coil_b_out_p_oe_n, coil_b_out_n, coil_b_out_n_oe_n;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int err_count, num_checks, ecmd;
   bit edis, eforce;
   sbd_bridge_ctrl #(.SLOT_CYC(SC)) dut (.*);
   sbd_master_model u_mst (.*);
   // ----------------------------------------------------------------
   // Checks and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Enables then levels; levels masked while a bridge floats
   task automatic chk_drv();
      logic [7:0] g, e;
      logic ea, eb;
      g = {coil_a_out_p_oe_n, coil_a_out_n_oe_n, coil_b_out_p_oe_n, coil_b_out_n_oe_n,
         coil_a_out_p & ~coil_a_out_p_oe_n, coil_a_out_n & ~coil_a_out_n_oe_n,
         coil_b_out_p & ~coil_b_out_p_oe_n, coil_b_out_n & ~coil_b_out_n_oe_n};
      ea = ecmd[2] & ecmd[0] & !edis & !eforce;
      eb = ecmd[2] & ecmd[4] & !edis & !eforce;
      e = {{2{~ea}}, {2{~eb}}, ea & ~ecmd[1], ea & ecmd[1], eb & ~ecmd[3], eb & ecmd[3]};
      chk({24'h0, g}, {24'h0, e});
      chk({31'h0, outputs_disabled}, {31'h0, edis});
   endtask : chk_drv
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'h1 | 4'($urandom);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Bench model tracks the latched command on a validated frame
   task automatic frame(input int c, input logic pv);
      u_mst.send(c[4:0], pv);
      if (pv) begin
         ecmd = c;
         edis = 0;
      end
      #1;
      chk_drv();
   endtask : frame
   task automatic results();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Far beyond the expected run of about four hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      results();
   end
   initial begin
      arst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
      err_count = 0;
      num_checks = 0;
      ecmd = 0;
      void'($urandom(32'hACF54C5F));
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      #1;
      chk_drv();
      rd(REG_HOLD);
      chk(rdv, 32'h9);
      rd(8'h0C);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h0C, 32'h1);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(REG_STATUS, 32'hFFFF_FFFF);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      rd(REG_STATUS);
      chk(rdv, 32'h200);
      foreach (STEPS[i]) frame(STEPS[i], 1'b1);
      for (int i = 0; i < 40; i++) begin
         frame(i < 32 ? i : int'($urandom % 32), 1'b1);
      end
      frame(ecmd ^ 31, 1'b0);
      u_mst.hold_low(7 * SC);
      u_mst.hold_low(7 * SC);
      #1;
      chk_drv();
      u_mst.hold_low(9 * SC + 10);
      edis = 1;
      #1;
      chk_drv();
      rd(REG_STATUS);
      chk(rdv, 32'h300 | ecmd);
      frame(21, 1'b1);
      wr(REG_HOLD, 32'h8);
      u_mst.hold_low(8 * SC + 10);
      edis = 1;
      #1;
      chk_drv();
      frame(29, 1'b1);
      wr(REG_CTRL, 32'h1);
      eforce = 1;
      #1;
      chk_drv();
      rd(REG_CTRL);
      chk(rdv, 32'h1);
      wr(REG_CTRL, 32'h0);
      eforce = 0;
      #1;
      chk_drv();
      // A zero limit is stored as one slot
      wr(REG_HOLD, 32'h0);
      rd(REG_HOLD);
      chk(rdv, 32'h1);
      results();
   end
endmodule : tb
bind sbd_bridge_ctrl sbd_asserts #(.SLOT_CYC(SLOT_CYC)) u_chk (.*);
